// file: include/gptm_consts.vh
`ifndef GPTM_CONSTS_VH
`define GPTM_CONSTS_VH

// Register indices; byte address is four times the index
`define GPTM_IDX_RELOAD        10'h0a0
`define GPTM_IDX_UF_SOURCE     10'h0a2
`define GPTM_IDX_CONTROL       10'h0a3
`define GPTM_IDX_COUNT         10'h0a4
`define GPTM_IDX_UF_MASK       10'h0a6

// Field positions
`define GPTM_SRC_UFLOW_BIT     0
`define GPTM_CTL_ENABLE_BIT    0
`define GPTM_CTL_RESET_BIT     1
`define GPTM_CTL_AUTODIS_BIT   2
`define GPTM_CTL_STATUS_BIT    7

// Reset values
`define GPTM_RELOAD_RST        16'hffff
`define GPTM_COUNT_RST         16'h0000

// AXI responses
`define GPTM_RESP_OKAY         2'h0
`define GPTM_RESP_SLVERR       2'h2

// Timing
`define GPTM_CLK_PERIOD_NS     4
`define GPTM_TICK_NS           1000000
`define GPTM_SETTLE_US         200
`define GPTM_TICK_CYCLES       ((`GPTM_TICK_NS + `GPTM_CLK_PERIOD_NS - 1) / `GPTM_CLK_PERIOD_NS)
`define GPTM_SETTLE_CYCLES     ((`GPTM_SETTLE_US * 1000 + `GPTM_CLK_PERIOD_NS - 1) / `GPTM_CLK_PERIOD_NS)

`endif

// file: logic/gptm_pulse_div.v
// Free divider: one-cycle pulse every DIV cycles while i_run is high
module gptm_pulse_div #(
   parameter integer CNT_W = 18,
   parameter integer DIV   = 250000
) (
   input  wire             i_clk,
   input  wire             i_rst_b,
   input  wire             i_ce,
   input  wire             i_run,
   output wire             o_pulse
);

   reg  [CNT_W-1:0] cnt_ff;
   reg  [CNT_W-1:0] nxt_cnt;
   wire             last;

   assign last    = (cnt_ff == DIV[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1});
   assign o_pulse = i_ce & i_run & last;

   // Phase restarts whenever the divider is stopped
   always @* begin
      nxt_cnt = cnt_ff;
      if (!i_run) begin
         nxt_cnt = {CNT_W{1'b0}};
      end else if (last) begin
         nxt_cnt = {CNT_W{1'b0}};
      end else begin
         nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_ff <= {CNT_W{1'b0}};
      end else if (i_ce) begin
         cnt_ff <= nxt_cnt;
      end
   end

endmodule // gptm_pulse_div

// file: logic/gptm_timer.v
// Local design decision: the AXI4-Lite slave port.
`include "gptm_consts.vh"

module gptm_timer #(
   parameter integer ADDR_W        = 12,
   parameter integer TICK_CYCLES   = `GPTM_TICK_CYCLES,
   parameter integer SETTLE_CYCLES = `GPTM_SETTLE_CYCLES,
   parameter integer TICK_W        = 18,
   parameter integer SETTLE_W      = 16
) (
   input  wire              i_clk,
   input  wire              i_rst_b,
   input  wire              i_ce,
   input  wire [ADDR_W-1:0] i_awaddr,
   input  wire              i_awvalid,
   output wire              o_awready,
   input  wire [31:0]       i_wdata,
   input  wire [3:0]        i_wstrb,
   input  wire              i_wvalid,
   output wire              o_wready,
   output wire [1:0]        o_bresp,
   output wire              o_bvalid,
   input  wire              i_bready,
   input  wire [ADDR_W-1:0] i_araddr,
   input  wire              i_arvalid,
   output wire              o_arready,
   output wire [31:0]       o_rdata,
   output wire [1:0]        o_rresp,
   output wire              o_rvalid,
   input  wire              i_rready,
   output wire              o_irq
);

   // Control and status state
   reg  [15:0]       reload_ff;
   reg  [15:0]       count_ff;
   reg               enable_ff;
   reg               reset_bit_ff;
   reg               autodis_ff;
   reg               running_ff;
   reg               pend_uf_ff;
   reg               uf_flag_ff;
   reg               uf_mask_ff;

   reg  [15:0]       nxt_reload;
   reg  [15:0]       nxt_count;
   reg               nxt_enable;
   reg               nxt_reset_bit;
   reg               nxt_autodis;
   reg               nxt_running;
   reg               nxt_pend_uf;
   reg               nxt_uf_flag;
   reg               nxt_uf_mask;

   // Bus state
   reg               bvalid_ff;
   reg  [1:0]        bresp_ff;
   reg               rvalid_ff;
   reg  [1:0]        rresp_ff;
   reg  [31:0]       rdata_ff;
   reg               nxt_bvalid;
   reg  [1:0]        nxt_bresp;
   reg               nxt_rvalid;
   reg  [1:0]        nxt_rresp;
   reg  [31:0]       nxt_rdata;

   wire              wr_go;
   wire              rd_go;
   wire [9:0]        wr_idx;
   wire [9:0]        rd_idx;
   wire              counting;
   wire              halting;
   wire              settle_run;
   wire              tick;
   wire              settle_done;
   wire              underflow;
   wire              wr_reload;
   wire              wr_src;
   wire              wr_ctl;
   wire              wr_mask;
   wire [7:0]        ctl_view;

   // Only the word index matters; byte-lane bits of the address are ignored
   function [9:0] word_idx;
      input [ADDR_W-1:0] addr;
      begin
         word_idx = addr[11:2];
      end
   endfunction

   function is_mapped;
      input [9:0] idx;
      begin
         is_mapped = (idx == `GPTM_IDX_RELOAD) || (idx == `GPTM_IDX_UF_SOURCE) ||
                     (idx == `GPTM_IDX_CONTROL) || (idx == `GPTM_IDX_COUNT) ||
                     (idx == `GPTM_IDX_UF_MASK);
      end
   endfunction

   // Address and data are taken together so a write never needs a holding buffer
   assign wr_go     = i_ce & i_awvalid & i_wvalid & ~bvalid_ff;
   assign o_awready = wr_go;
   assign o_wready  = wr_go;
   assign rd_go     = i_ce & i_arvalid & ~rvalid_ff;
   assign o_arready = i_ce & ~rvalid_ff;
   assign o_bvalid  = bvalid_ff;
   assign o_bresp   = bresp_ff;
   assign o_rvalid  = rvalid_ff;
   assign o_rresp   = rresp_ff;
   assign o_rdata   = rdata_ff;

   assign wr_idx    = word_idx(i_awaddr);
   assign rd_idx    = word_idx(i_araddr);
   assign wr_reload = wr_go & (wr_idx == `GPTM_IDX_RELOAD);
   assign wr_src    = wr_go & (wr_idx == `GPTM_IDX_UF_SOURCE) & i_wstrb[0];
   assign wr_ctl    = wr_go & (wr_idx == `GPTM_IDX_CONTROL) & i_wstrb[0];
   assign wr_mask   = wr_go & (wr_idx == `GPTM_IDX_UF_MASK) & i_wstrb[0];

   assign counting   = enable_ff & running_ff & ~reset_bit_ff & ~pend_uf_ff;
   // A timer disabled without the reset bit keeps reporting running until the halt has settled
   assign halting    = running_ff & ~enable_ff;
   assign settle_run = halting | reset_bit_ff;

   gptm_pulse_div #(
      .CNT_W (TICK_W),
      .DIV   (TICK_CYCLES)
   ) u_tick (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_ce    (i_ce),
      .i_run   (counting),
      .o_pulse (tick)
   );

   gptm_pulse_div #(
      .CNT_W (SETTLE_W),
      .DIV   (SETTLE_CYCLES)
   ) u_settle (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_ce    (i_ce),
      .i_run   (settle_run),
      .o_pulse (settle_done)
   );

   assign underflow = tick & (count_ff == 16'h0001);

   assign ctl_view = {running_ff, 4'h0, autodis_ff, reset_bit_ff, enable_ff};

   // Timer state
   always @* begin
      nxt_reload    = reload_ff;
      nxt_count     = count_ff;
      nxt_enable    = enable_ff;
      nxt_reset_bit = reset_bit_ff;
      nxt_autodis   = autodis_ff;
      nxt_running   = running_ff;
      nxt_pend_uf   = pend_uf_ff;
      nxt_uf_flag   = uf_flag_ff;
      nxt_uf_mask   = uf_mask_ff;

      if (wr_reload && i_wstrb[0]) begin
         nxt_reload[7:0] = i_wdata[7:0];
      end
      if (wr_reload && i_wstrb[1]) begin
         nxt_reload[15:8] = i_wdata[15:8];
      end
      if (wr_mask) begin
         nxt_uf_mask = i_wdata[`GPTM_SRC_UFLOW_BIT];
      end

      // Counter decrements only while counting; stopping keeps the count
      if (tick && !underflow) begin
         nxt_count = count_ff - 16'h0001;
      end

      if (underflow) begin
         nxt_count = reload_ff;
         if (autodis_ff) begin
            nxt_enable  = 1'b0;
            nxt_pend_uf = 1'b1;
         end else begin
            nxt_uf_flag = 1'b1;
         end
      end

      if (settle_done) begin
         nxt_reset_bit = 1'b0;
         if (halting) begin
            nxt_running = 1'b0;
         end
         if (pend_uf_ff) begin
            nxt_uf_flag = 1'b1;
            nxt_pend_uf = 1'b0;
         end
      end

      // Start is immediate; a re-enable during a halt simply cancels the halt
      if (enable_ff && !running_ff && !reset_bit_ff && !pend_uf_ff) begin
         nxt_running = 1'b1;
      end

      if (wr_ctl) begin
         nxt_enable  = i_wdata[`GPTM_CTL_ENABLE_BIT];
         nxt_autodis = i_wdata[`GPTM_CTL_AUTODIS_BIT];
         if (i_wdata[`GPTM_CTL_RESET_BIT]) begin
            nxt_reset_bit = 1'b1;
            nxt_running   = 1'b0;
            nxt_count     = reload_ff;
         end
      end

      // Counter follows reload while in reset
      if (reset_bit_ff) begin
         nxt_count = reload_ff;
      end

      // Write-one clears; a same-cycle flag set wins (underflow with autodis off, or settle of a pending underflow)
      if (wr_src && i_wdata[`GPTM_SRC_UFLOW_BIT] && !nxt_uf_flag_set(underflow, autodis_ff,
                                                                      settle_done, pend_uf_ff)) begin
         nxt_uf_flag = 1'b0;
      end
   end

   function nxt_uf_flag_set;
      input uf;
      input ad;
      input sd;
      input pend;
      begin
         nxt_uf_flag_set = (uf & ~ad) | (sd & pend);
      end
   endfunction

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         reload_ff    <= `GPTM_RELOAD_RST;
         count_ff     <= `GPTM_COUNT_RST;
         enable_ff    <= 1'b0;
         reset_bit_ff <= 1'b0;
         autodis_ff   <= 1'b0;
         running_ff   <= 1'b0;
         pend_uf_ff   <= 1'b0;
         uf_flag_ff   <= 1'b0;
         uf_mask_ff   <= 1'b0;
      end else if (i_ce) begin
         reload_ff    <= nxt_reload;
         count_ff     <= nxt_count;
         enable_ff    <= nxt_enable;
         reset_bit_ff <= nxt_reset_bit;
         autodis_ff   <= nxt_autodis;
         running_ff   <= nxt_running;
         pend_uf_ff   <= nxt_pend_uf;
         uf_flag_ff   <= nxt_uf_flag;
         uf_mask_ff   <= nxt_uf_mask;
      end
   end

   assign o_irq = uf_flag_ff & uf_mask_ff;

   // Write response channel
   always @* begin
      nxt_bvalid = bvalid_ff;
      nxt_bresp  = bresp_ff;
      if (bvalid_ff && i_bready) begin
         nxt_bvalid = 1'b0;
      end
      if (wr_go) begin
         nxt_bvalid = 1'b1;
         nxt_bresp  = is_mapped(wr_idx) ? `GPTM_RESP_OKAY : `GPTM_RESP_SLVERR;
      end
   end

   // Read data channel
   always @* begin
      nxt_rvalid = rvalid_ff;
      nxt_rresp  = rresp_ff;
      nxt_rdata  = rdata_ff;
      if (rvalid_ff && i_rready) begin
         nxt_rvalid = 1'b0;
      end
      if (rd_go) begin
         nxt_rvalid = 1'b1;
         nxt_rresp  = `GPTM_RESP_OKAY;
         nxt_rdata  = 32'h0000_0000;
         case (rd_idx)
            `GPTM_IDX_RELOAD: begin
               nxt_rdata[15:0] = reload_ff;
            end
            `GPTM_IDX_UF_SOURCE: begin
               nxt_rdata[`GPTM_SRC_UFLOW_BIT] = uf_flag_ff;
            end
            `GPTM_IDX_CONTROL: begin
               nxt_rdata[7:0] = ctl_view;
            end
            `GPTM_IDX_COUNT: begin
               nxt_rdata[15:0] = count_ff;
            end
            `GPTM_IDX_UF_MASK: begin
               nxt_rdata[`GPTM_SRC_UFLOW_BIT] = uf_mask_ff;
            end
            default: begin
               nxt_rresp = `GPTM_RESP_SLVERR;
            end
         endcase
      end
   end

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= `GPTM_RESP_OKAY;
         rvalid_ff <= 1'b0;
         rresp_ff  <= `GPTM_RESP_OKAY;
         rdata_ff  <= 32'h0000_0000;
      end else if (i_ce) begin
         bvalid_ff <= nxt_bvalid;
         bresp_ff  <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rresp_ff  <= nxt_rresp;
         rdata_ff  <= nxt_rdata;
      end
   end

endmodule // gptm_timer

// file: verification/gptm_timer_sva.sv
`include "gptm_consts.vh"
module gptm_timer_chk #(
   parameter integer ADDR_W = 12
) (
   input logic              i_clk,
   input logic              i_rst_b,
   input logic              i_awvalid,
   input logic              o_awready,
   input logic              i_wvalid,
   input logic              o_wready,
   input logic [1:0]        o_bresp,
   input logic              o_bvalid,
   input logic              i_bready,
   input logic [ADDR_W-1:0] i_araddr,
   input logic              i_arvalid,
   input logic              o_arready,
   input logic [31:0]       o_rdata,
   input logic [1:0]        o_rresp,
   input logic              o_rvalid,
   input logic              i_rready,
   input logic              o_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   sequence s_wr_take;
      i_awvalid && i_wvalid && o_awready;
   endsequence
   sequence s_rd_take;
      i_arvalid && o_arready;
   endsequence
   property p_wr_ans;
      s_wr_take |=> o_bvalid;
   endproperty
   property p_rd_ans;
      s_rd_take |=> o_rvalid;
   endproperty
   property p_b_hold;
      o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
   endproperty
   property p_r_hold;
      o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp);
   endproperty
   property p_w_block;
      o_bvalid |-> !o_awready && !o_wready;
   endproperty
   property p_rdy_pair;
      o_awready == o_wready;
   endproperty
   property p_unmap;
      s_rd_take ##0 (i_araddr[ADDR_W-1:2] > `GPTM_IDX_UF_MASK) |=>
         o_rresp == `GPTM_RESP_SLVERR && o_rdata == 32'h0;
   endproperty
   property p_src_rsv;
      s_rd_take ##0 (i_araddr[ADDR_W-1:2] == `GPTM_IDX_UF_SOURCE) |=> o_rdata[31:1] == 31'h0;
   endproperty
   // Flag only clears by a bus write, so the interrupt cannot drop on its own
   property p_irq_fall;
      $fell(o_irq) |-> $past(o_awready && i_awvalid);
   endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
   a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   a_r_hold: assert property (p_r_hold) else $error("read answer changed");
   a_w_block: assert property (p_w_block) else $error("write taken during answer");
   a_rdy_pair: assert property (p_rdy_pair) else $error("readies differ");
   a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
   a_src_rsv: assert property (p_src_rsv) else $error("source spare bits set");
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
endmodule // gptm_timer_chk

bind gptm_timer gptm_timer_chk #(.ADDR_W(ADDR_W)) gptm_timer_chk_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
   .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
   .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
   .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_irq(o_irq));

// file: verification/gptm_timer_test.sv
`include "gptm_consts.vh"
module gptm_timer_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] A_RL = {`GPTM_IDX_RELOAD, 2'h0};
   localparam logic [11:0] A_SR = {`GPTM_IDX_UF_SOURCE, 2'h0};
   localparam logic [11:0] A_CT = {`GPTM_IDX_CONTROL, 2'h0};
   localparam logic [11:0] A_CN = {`GPTM_IDX_COUNT, 2'h0};
   localparam logic [11:0] A_MK = {`GPTM_IDX_UF_MASK, 2'h0};
   logic        i_clk, i_rst_b, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
   logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
   logic [11:0] i_awaddr, i_araddr;
   logic [31:0] i_wdata, o_rdata, last_d;
   logic [3:0]  i_wstrb;
   logic [1:0]  o_bresp, o_rresp;
   logic [15:0] lf, rl;
   logic [65:0] rq[$];
   logic [1:0]  bq[$];
   int          err_total, compares, cyc, k;
   int          take_cyc, rise_cyc;
   logic        ce, irq_prev;
   localparam int TK = 8;
   localparam int ST = 5;

   gptm_timer #(.TICK_CYCLES(TK), .SETTLE_CYCLES(ST)) gptm_timer_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
      .i_ce(ce), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
      .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
      .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
      .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_irq(o_irq));

   always #2 i_clk = ~i_clk;

   function automatic logic [15:0] lfsr_step(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic complete_run;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Ready is combinational, so it is judged at the falling edge before the taking edge
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
                     input logic [1:0] r = `GPTM_RESP_OKAY);
      @(posedge i_clk);
      bq.push_back(r);
      i_awaddr <= a;
      i_wdata <= d;
      i_wstrb <= s;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      do @(negedge i_clk); while (!o_awready);
      @(posedge i_clk);
      i_awvalid <= 1'b0;
      i_wvalid <= 1'b0;
      @(posedge i_clk);
      i_bready <= 1'b1;
      do @(negedge i_clk); while (!o_bvalid);
      @(posedge i_clk);
      i_bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m = '1,
                     input logic [1:0] r = `GPTM_RESP_OKAY);
      @(posedge i_clk);
      rq.push_back({r, d, m});
      i_araddr <= a;
      i_arvalid <= 1'b1;
      do @(negedge i_clk); while (!o_arready);
      @(posedge i_clk);
      i_arvalid <= 1'b0;
      @(posedge i_clk);
      i_rready <= 1'b1;
      do @(negedge i_clk); while (!o_rvalid);
      last_d = o_rdata;
      @(posedge i_clk);
      i_rready <= 1'b0;
   endtask

   task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
      k = 0;
      do begin
         rd(a, 0, 0);
         k++;
      end while ((last_d & m) !== v && k < 60);
      chk(last_d & m, v);
   endtask

   always @(posedge i_clk) begin
      logic [65:0] e;
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         complete_run();
      end
      if (o_rvalid && i_rready) begin
         e = rq.pop_front();
         chk({o_rresp, o_rdata & e[31:0]}, {e[65:64], e[63:32] & e[31:0]});
      end
      if (o_bvalid && i_bready)
         chk(o_bresp, bq.pop_front());
      // Edge of the last write taken and edge at which the interrupt is first seen high
      if (o_awready && i_awvalid)
         take_cyc = cyc;
      if (o_irq && !irq_prev)
         rise_cyc = cyc;
      irq_prev = o_irq;
   end

   initial begin
      {i_clk, i_rst_b, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
      {i_awaddr, i_araddr, i_wdata, i_wstrb} = '0;
      ce = 1'b1;
      irq_prev = 1'b0;
      take_cyc = 0;
      rise_cyc = 0;
      err_total = 0;
      compares = 0;
      cyc = 0;
      lf = 16'h0040;
      repeat (12) @(posedge i_clk);
      i_rst_b <= 1'b1;
      rd(A_RL, 32'hffff);
      rd(A_SR, 0);
      rd(A_CT, 0);
      rd(A_CN, 0);
      rd(A_MK, 0);
      rd(12'h2a0, 0, '1, `GPTM_RESP_SLVERR);
      wr(12'h2a0, 1, 4'hf, `GPTM_RESP_SLVERR);
      // A nonzero seed keeps every reload value nonzero
      for (int i = 0; i < 4; i++) begin
         lf = lfsr_step(lf);
         wr(A_RL, {16'h0, lf});
         rd(A_RL, {16'h0, lf});
      end
      wr(A_RL, 32'h12, 4'h1);
      rd(A_RL, {16'h0, lf[15:8], 8'h12});
      rl = {14'h0, lf[1:0]} + 16'h2;
      wr(A_RL, rl);
      wr(A_CT, 32'h2);
      // Clock enable low must freeze the reset settle count
      @(posedge i_clk);
      ce <= 1'b0;
      repeat (20) @(posedge i_clk);
      ce <= 1'b1;
      rd(A_CT, 32'h2, 32'h82);
      poll(A_CT, 32'h2, 0);
      rd(A_CN, rl);
      repeat (40) @(posedge i_clk);
      rd(A_CN, rl);
      wr(A_MK, 1);
      wr(A_CT, 1);
      rd(A_CT, 32'h80, 32'h80);
      poll(A_SR, 1, 1);
      // One cycle to start, one tick period per count, one to sample
      chk(rise_cyc - take_cyc, TK * rl + 2);
      @(negedge i_clk);
      chk(o_irq, 1);
      wr(A_SR, 1);
      @(negedge i_clk);
      chk(o_irq, 0);
      poll(A_SR, 1, 1);
      wr(A_MK, 0);
      @(negedge i_clk);
      chk(o_irq, 0);
      wr(A_CT, 0);
      poll(A_CT, 32'h80, 0);
      rd(A_CN, 0, 0);
      repeat (40) @(posedge i_clk);
      rd(A_CN, last_d);
      wr(A_SR, 1);
      rd(A_SR, 0);
      wr(A_CT, 32'h2);
      poll(A_CT, 32'h2, 0);
      wr(A_MK, 1);
      wr(A_CT, 32'h5);
      poll(A_SR, 1, 1);
      // The flag waits a full halt settle after the underflow
      chk(rise_cyc - take_cyc, TK * rl + 2 + ST);
      rd(A_CT, 32'h04);
      complete_run();
   end
endmodule // gptm_timer_test
